// ===== design/cmf_mailbox_filter.v
// Mailbox access protection, transmit selection and acceptance filter of a CAN controller.
//
// Notes on behaviour
// - Identifier word is writable only while the mailbox is disabled.
// - Data words of an enabled receive mailbox refuse CPU writes.
// - Pending or aborting transmit mailbox refuses data writes and flags write-denied.
// - Change-data-request checked before and after fetch; hit skips, scanning continues.
// - No write-denied event while change-data-request is set.
// - Control word keeps priority 12:8, remote bit 4, length 3:0; rest zero.
// - Highest priority value sends first; ties go to the higher mailbox.
// - Priority counts for transmit only and is ignored in sixteen-mailbox mode.
// - Receive mailbox with remote bit sends remote frame, request cleared after sending.
// - Transmit mailbox with remote bit sends remote frame; answer lands elsewhere.
// - Control word readable always, writable when disabled or set for transmit.
// - Byte order bit one puts byte 0 low; zero puts it at bits 31:24.
// - Data writes need transmit or disabled, and no request unless selected for update.
// - Data bytes beyond the received length are overwritten with whatever arrived.
// - Filter compares stored and incoming identifiers except bits the mask excludes.
// - Sixteen-mailbox mode stores in the highest matching mailbox, upper group first.
// - Sixteen-mailbox mode: mailboxes 5..3 use mask 3, 2..0 use mask 0.
// - Enhanced mode gives every mailbox its own mask; mode picks the masks.
// - Mask bit one is don't care; zero demands equality.
// - Extension-ignore accepts both formats; otherwise stored extension bit decides format.
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "cmf_regs.vh"

module cmf_mailbox_filter #(
    parameter NMB = 32
) (
    input  wire         clock,
    input  wire         srst,
    input  wire         psel,
    input  wire         penable,
    input  wire         pwrite,
    input  wire [11:0]  paddr,
    input  wire [31:0]  pwdata,
    output wire [31:0]  prdata,
    output wire         pready,
    output wire         pslverr,
    output wire         tx_pending,
    output reg  [4:0]   tx_sel_mbox,
    input  wire         tx_fetch,
    output reg          tx_frame_valid,
    output reg          tx_skip,
    output reg  [4:0]   tx_mbox,
    output reg  [28:0]  tx_id,
    output reg          tx_ide,
    output reg          tx_remote,
    output reg  [3:0]   tx_dlc,
    output reg  [63:0]  tx_bytes,
    input  wire         tx_done,
    input  wire         tx_done_ok,
    input  wire         rx_valid,
    input  wire [28:0]  rx_id,
    input  wire         rx_ide,
    input  wire         rx_rtr,
    input  wire [3:0]   rx_dlc,
    input  wire [63:0]  rx_bytes,
    output reg          rx_accept,
    output reg  [4:0]   rx_mbox,
    output reg          write_denied_interrupt
);
    localparam ST_IDLE = 2'd0;
    localparam ST_READ = 2'd1;
    localparam ST_BUSY = 2'd2;

    reg  [31:0] enable_r;
    reg  [31:0] dir_r;
    reg  [31:0] trs_r;
    reg  [31:0] trr_r;
    reg  [31:0] mctrl_r;
    reg  [31:0] gmask_r;
    reg  [31:0] skip_r;
    reg         wd_flag_r;
    reg  [1:0]  state_r;
    reg  [31:0] prdata_r;
    reg         sel_mem_r;
    reg         half_r;
    reg  [31:0] rd_mux;
    reg         rd_map;
    reg  [4:0]  rx_sel;

    wire [31:0] id_w    [0:31];
    wire [31:0] ctrl_w  [0:31];
    wire [31:0] lmask_w [0:31];
    wire [31:0] rx_hit;
    wire [31:0] tx_cand;
    wire [63:0] mem_a_rd;
    wire [63:0] mem_b_rd;

    // Byte lanes of a data word swap when the order bit is clear.
    function [31:0] order_word;
        input [31:0] w;
        input        lsb_first;
        begin
            order_word = lsb_first ? w : {w[7:0], w[15:8], w[23:16], w[31:24]};
        end
    endfunction

    // One mailbox's acceptance test; the mask only counts when the mailbox enables it.
    function fmatch;
        input [28:0] rid;
        input        rext;
        input [31:0] id;
        input [31:0] m;
        reg          ext;
        reg          fmt_ok;
        reg   [28:0] dc;
        reg   [28:0] cmp;
        begin
            if (id[`CMF_ID_AME] && m[`CMF_MASK_MI])
            begin
                ext    = rext;
                fmt_ok = 1'b1;
            end
            else
            begin
                ext    = id[`CMF_ID_IDE];
                fmt_ok = (id[`CMF_ID_IDE] == rext);
            end
            dc     = id[`CMF_ID_AME] ? m[28:0] : 29'h00000000;
            cmp    = ext ? `CMF_CMP_EXT : `CMF_CMP_STD;
            fmatch = fmt_ok && (((rid ^ id[28:0]) & ~dc & cmp) == 29'h00000000);
        end
    endfunction

    // Master control fields in use.
    wire       change_data_request    = mctrl_r[`CMF_MC_CDR];
    wire [4:0] mailbox_number_select   = mctrl_r[`CMF_MC_MAILBOX_NUMBER_SELECT_HI:0];
    wire       data_byte_order    = mctrl_r[`CMF_MC_DBO];
    wire       init   = mctrl_r[`CMF_MC_INIT];
    wire       compat = mctrl_r[`CMF_MC_COMPAT];

    // APB decode; the slave never inserts wait states.
    wire       acc      = psel & penable;
    wire       setup    = psel & ~penable;
    wire       wr_acc   = acc & pwrite;
    wire       is_mb    = ((paddr & `CMF_MBOX_SEL) == `CMF_MBOX_BASE);
    wire       is_lm    = ((paddr & `CMF_LMASK_SEL) == `CMF_LMASK_BASE);
    wire [4:0] mb_n     = paddr[8:4];
    wire [1:0] mb_word  = paddr[3:2];
    wire [4:0] lm_n     = paddr[6:2];
    wire       is_data  = is_mb && mb_word[1];
    wire       upd_sel  = change_data_request && (mailbox_number_select == mb_n);
    wire       tx_block = (trs_r[mb_n] | trr_r[mb_n]) & ~upd_sel;
    wire       data_ok  = (~enable_r[mb_n] | ~dir_r[mb_n]) & ~tx_block;
    wire       data_we  = wr_acc & is_data & data_ok;
    wire       wd_event = wr_acc & is_data & ~dir_r[mb_n] & tx_block & ~change_data_request;
    wire       mask_ok  = ~compat | init;

    // Global register read mux; the mailbox and mask windows are read per slot.
    always @*
    begin
        rd_mux = `CMF_ZERO32;
        rd_map = 1'b1;
        if (is_mb)
        begin
            if (mb_word == `CMF_MB_WORD_ID)
                rd_mux = id_w[mb_n];
            else if (mb_word == `CMF_MB_WORD_CTRL)
                rd_mux = ctrl_w[mb_n];
        end
        else if (is_lm)
            rd_mux = lmask_w[lm_n];
        else
        begin
            case (paddr)
                `CMF_OFF_ENABLE: rd_mux = enable_r;
                `CMF_OFF_DIR:    rd_mux = dir_r;
                `CMF_OFF_TRS:    rd_mux = trs_r;
                `CMF_OFF_TRR:    rd_mux = trr_r;
                `CMF_OFF_MCTRL:  rd_mux = mctrl_r;
                `CMF_OFF_GMASK:  rd_mux = gmask_r;
                `CMF_OFF_STATUS: rd_mux = {16'h0000, tx_pending, 2'b00, tx_sel_mbox,
                                           6'h00, (skip_r != `CMF_ZERO32), wd_flag_r};
                default:         rd_map = 1'b0;
            endcase
        end
    end

    // Read data is captured in the setup cycle; data words come from the memory register.
    always @(posedge clock)
    begin
        if (srst)
        begin
            prdata_r  <= `CMF_ZERO32;
            sel_mem_r <= 1'b0;
            half_r    <= 1'b0;
        end
        else if (setup)
        begin
            prdata_r  <= rd_mux;
            sel_mem_r <= is_data;
            half_r    <= mb_word[0];
        end
    end

    assign prdata  = sel_mem_r ? (half_r ? mem_a_rd[63:32] : mem_a_rd[31:0]) : prdata_r;
    assign pready  = 1'b1;
    assign pslverr = acc & ~rd_map;

    // Per-mailbox identifier, control and mask words with their filter and candidate terms.
    genvar gi;
    generate
        for (gi = 0; gi < NMB; gi = gi + 1)
        begin : g_mb
            reg  [31:0] id_r;
            reg  [31:0] ctrl_r;
            reg  [31:0] lmask_r;
            wire        sel_here = is_mb && (mb_n == gi);
            wire        id_we    = wr_acc && sel_here && (mb_word == `CMF_MB_WORD_ID)
                                   && !enable_r[gi];
            wire        ctrl_we  = wr_acc && sel_here && (mb_word == `CMF_MB_WORD_CTRL)
                                   && (!enable_r[gi] || !dir_r[gi]);
            wire        lm_we    = wr_acc && is_lm && (lm_n == gi) && mask_ok;
            wire        exists   = !compat || (gi < 16);
            wire        store    = rx_valid && rx_hit[gi] && dir_r[gi] && (rx_sel == gi);
            wire [31:0] msel     = !compat ? lmask_r :
                                   (gi >= 6) ? gmask_r :
                                   (gi >= 3) ? lmask_w[3] : lmask_w[0];

            always @(posedge clock)
            begin
                if (srst)
                begin
                    id_r    <= `CMF_ZERO32;
                    ctrl_r  <= `CMF_ZERO32;
                    lmask_r <= `CMF_ZERO32;
                end
                else
                begin
                    if (store)
                    begin
                        id_r[28:0]        <= rx_id;
                        id_r[`CMF_ID_IDE] <= rx_ide;
                    end
                    else if (id_we)
                        id_r <= pwdata;
                    if (store)
                        ctrl_r[`CMF_CTRL_DLC_HI:0] <= rx_dlc;
                    else if (ctrl_we)
                        ctrl_r <= pwdata & `CMF_CTRL_MASK;
                    if (lm_we)
                        lmask_r <= pwdata & `CMF_MASK_RW;
                end
            end

            assign id_w[gi]    = id_r;
            assign ctrl_w[gi]  = ctrl_r;
            assign lmask_w[gi] = lmask_r;
            // Data frames go to receive mailboxes, remote frames to auto-reply transmit ones.
            assign rx_hit[gi]  = exists && enable_r[gi] && fmatch(rx_id, rx_ide, id_r, msel)
                                 && ((dir_r[gi] && !rx_rtr) ||
                                     (!dir_r[gi] && id_r[`CMF_ID_AAM] && rx_rtr));
            // A receive mailbox only transmits when its remote bit asks for it.
            assign tx_cand[gi] = exists && enable_r[gi] && trs_r[gi] && !trr_r[gi]
                                 && !skip_r[gi]
                                 && (!dir_r[gi] || ctrl_r[`CMF_CTRL_RTR]);
        end
    endgenerate

    // Receive winner: highest numbered hit, which also yields the group order of compat mode.
    integer   ri;
    always @*
    begin
        rx_sel = 5'h00;
        for (ri = 0; ri < NMB; ri = ri + 1)
            if (rx_hit[ri])
                rx_sel = ri[4:0];
    end

    // Transmit winner: ascending scan with >= lets the higher mailbox take a tie.
    reg [4:0] best_tpl;
    reg       tx_any;
    integer   ti;
    always @*
    begin
        tx_sel_mbox = 5'h00;
        best_tpl    = 5'h00;
        tx_any      = 1'b0;
        for (ti = 0; ti < NMB; ti = ti + 1)
            if (tx_cand[ti] && (compat ||
                ctrl_w[ti][`CMF_CTRL_TPL_HI:`CMF_CTRL_TPL_LO] >= best_tpl))
            begin
                tx_sel_mbox = ti[4:0];
                best_tpl    = compat ? 5'h00 : ctrl_w[ti][`CMF_CTRL_TPL_HI:`CMF_CTRL_TPL_LO];
                tx_any      = 1'b1;
            end
    end

    assign tx_pending = tx_any && (state_r == ST_IDLE);

    wire        rx_fire  = rx_valid && (rx_hit != `CMF_ZERO32);
    wire        rx_data  = rx_fire && dir_r[rx_sel];
    wire [63:0] rx_store = {order_word(rx_bytes[63:32], data_byte_order),
                            order_word(rx_bytes[31:0], data_byte_order)};
    wire        chk_pre  = change_data_request && (mailbox_number_select == tx_sel_mbox);
    wire        chk_post = change_data_request && (mailbox_number_select == tx_mbox);

    // Slot that the fetch and abort logic must not drop while it is in flight.
    wire [31:0] hold_oh  = (state_r != ST_IDLE) ? (32'h00000001 << tx_mbox) : `CMF_ZERO32;
    wire [31:0] done_clr = (state_r == ST_BUSY && tx_done && tx_done_ok) ? hold_oh : `CMF_ZERO32;
    wire [31:0] abrt_clr = trr_r & ~hold_oh;
    wire [31:0] cpu_trs  = (wr_acc && paddr == `CMF_OFF_TRS) ? pwdata : `CMF_ZERO32;
    wire [31:0] cpu_trr  = (wr_acc && paddr == `CMF_OFF_TRR) ? pwdata : `CMF_ZERO32;
    wire [31:0] auto_set = (rx_fire && !dir_r[rx_sel]) ? (32'h00000001 << rx_sel) : `CMF_ZERO32;
    wire [31:0] skip_set = (state_r == ST_IDLE && tx_fetch && tx_any && chk_pre) ?
                           (32'h00000001 << tx_sel_mbox) :
                           (state_r == ST_READ && chk_post) ? hold_oh : `CMF_ZERO32;

    // Global registers; a hardware set always wins over a clear in the same cycle.
    always @(posedge clock)
    begin
        if (srst)
        begin
            enable_r  <= `CMF_ZERO32;
            dir_r     <= `CMF_ZERO32;
            trs_r     <= `CMF_ZERO32;
            trr_r     <= `CMF_ZERO32;
            mctrl_r   <= `CMF_MC_RESET;
            gmask_r   <= `CMF_ZERO32;
            skip_r    <= `CMF_ZERO32;
            wd_flag_r <= 1'b0;
            write_denied_interrupt <= 1'b0;
        end
        else
        begin
            if (wr_acc && paddr == `CMF_OFF_ENABLE)
                enable_r <= pwdata;
            if (wr_acc && paddr == `CMF_OFF_DIR)
                dir_r <= pwdata;
            if (wr_acc && paddr == `CMF_OFF_MCTRL)
                mctrl_r <= pwdata & `CMF_MC_MASK;
            if (wr_acc && paddr == `CMF_OFF_GMASK && mask_ok)
                gmask_r <= pwdata & `CMF_MASK_RW;
            trs_r <= (trs_r & ~done_clr & ~abrt_clr) | cpu_trs | auto_set;
            trr_r <= (trr_r & ~done_clr & ~abrt_clr) | cpu_trr;
            // Skipped slots wait until the update flag is released, then rejoin the scan.
            skip_r <= (change_data_request ? skip_r : `CMF_ZERO32) | skip_set;
            if (wd_event)
                wd_flag_r <= 1'b1;
            else if (wr_acc && paddr == `CMF_OFF_STATUS && pwdata[`CMF_ST_WD])
                wd_flag_r <= 1'b0;
            write_denied_interrupt <= wd_event;
        end
    end

    // Transmit fetch sequence: check, read, check again, then hold until the engine reports.
    always @(posedge clock)
    begin
        if (srst)
        begin
            state_r        <= ST_IDLE;
            tx_frame_valid <= 1'b0;
            tx_skip        <= 1'b0;
            tx_mbox        <= 5'h00;
            tx_id          <= 29'h00000000;
            tx_ide         <= 1'b0;
            tx_remote      <= 1'b0;
            tx_dlc         <= 4'h0;
            tx_bytes       <= 64'h0000000000000000;
        end
        else
        begin
            tx_frame_valid <= 1'b0;
            tx_skip        <= 1'b0;
            case (state_r)
                ST_IDLE:
                begin
                    if (tx_fetch && tx_any)
                    begin
                        if (chk_pre)
                            tx_skip <= 1'b1;
                        else
                        begin
                            tx_mbox <= tx_sel_mbox;
                            state_r <= ST_READ;
                        end
                    end
                end
                ST_READ:
                begin
                    if (chk_post)
                    begin
                        tx_skip <= 1'b1;
                        state_r <= ST_IDLE;
                    end
                    else
                    begin
                        tx_id          <= id_w[tx_mbox][28:0];
                        tx_ide         <= id_w[tx_mbox][`CMF_ID_IDE];
                        tx_remote      <= ctrl_w[tx_mbox][`CMF_CTRL_RTR];
                        tx_dlc         <= ctrl_w[tx_mbox][`CMF_CTRL_DLC_HI:0];
                        tx_bytes       <= {order_word(mem_b_rd[63:32], data_byte_order),
                                           order_word(mem_b_rd[31:0], data_byte_order)};
                        tx_frame_valid <= 1'b1;
                        state_r        <= ST_BUSY;
                    end
                end
                ST_BUSY:
                begin
                    if (tx_done)
                        state_r <= ST_IDLE;
                end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    // Receive report, registered at the same edge as the store.
    always @(posedge clock)
    begin
        if (srst)
        begin
            rx_accept <= 1'b0;
            rx_mbox   <= 5'h00;
        end
        else
        begin
            rx_accept <= rx_fire;
            if (rx_fire)
                rx_mbox <= rx_sel;
        end
    end

    cmf_mbox_mem #(
        .HALF_W (32),
        .ADDR_W (5)
    ) u_mem (
        .clock   (clock),
        .srst    (srst),
        .a_we    ({data_we & mb_word[0], data_we & ~mb_word[0]}),
        .a_addr  (mb_n),
        .a_wdata (pwdata),
        .a_rdata (mem_a_rd),
        .b_addr  ((state_r == ST_IDLE) ? tx_sel_mbox : tx_mbox),
        .b_rdata (mem_b_rd),
        .c_we    (rx_data),
        .c_addr  (rx_sel),
        .c_wdata (rx_store)
    );
endmodule

`default_nettype wire

// ===== design/cmf_regs.vh
// Register offsets, field positions and reset values of the mailbox and filter block.
`ifndef CMF_REGS_VH
`define CMF_REGS_VH

// Global register byte offsets.
`define CMF_OFF_ENABLE     12'h000
`define CMF_OFF_DIR        12'h004
`define CMF_OFF_TRS        12'h008
`define CMF_OFF_TRR        12'h00C
`define CMF_OFF_MCTRL      12'h010
`define CMF_OFF_GMASK      12'h014
`define CMF_OFF_STATUS     12'h018

// Local mask window and mailbox window, with the address bits that select them.
`define CMF_LMASK_BASE     12'h100
`define CMF_LMASK_SEL      12'hF80
`define CMF_MBOX_BASE      12'h200
`define CMF_MBOX_SEL       12'hE00

// Word inside one mailbox slot of sixteen bytes.
`define CMF_MB_WORD_ID     2'h0
`define CMF_MB_WORD_CTRL   2'h1
`define CMF_MB_WORD_LOW    2'h2
`define CMF_MB_WORD_HIGH   2'h3

// Master control fields.
`define CMF_MC_MAILBOX_NUMBER_SELECT_HI     4
`define CMF_MC_CDR         8
`define CMF_MC_DBO         10
`define CMF_MC_INIT        12
`define CMF_MC_COMPAT      13
`define CMF_MC_MASK        32'h0000351F
`define CMF_MC_RESET       32'h00001000

// Message control fields.
`define CMF_CTRL_TPL_HI    12
`define CMF_CTRL_TPL_LO    8
`define CMF_CTRL_RTR       4
`define CMF_CTRL_DLC_HI    3
`define CMF_CTRL_MASK      32'h00001F1F

// Identifier word fields.
`define CMF_ID_IDE         31
`define CMF_ID_AME         30
`define CMF_ID_AAM         29

// Mask word fields; bits 30:29 are reserved.
`define CMF_MASK_MI        31
`define CMF_MASK_RW        32'h9FFFFFFF

// Identifier compare spans for extended and standard frames.
`define CMF_CMP_EXT        29'h1FFFFFFF
`define CMF_CMP_STD        29'h1FFC0000

// Status fields.
`define CMF_ST_WD          0
`define CMF_ST_SKIP        1
`define CMF_ST_TXV         15

// Reset value of the ordinary registers.
`define CMF_ZERO32         32'h00000000

`endif

// ===== design/cmf_mbox_mem.v
// Mailbox data storage: one CPU port, one transmit read port, one receive write port.
`timescale 1ns/1ps
`default_nettype none

module cmf_mbox_mem #(
    parameter HALF_W = 32,
    parameter ADDR_W = 5
) (
    input  wire                  clock,
    input  wire                  srst,
    input  wire [1:0]            a_we,
    input  wire [ADDR_W-1:0]     a_addr,
    input  wire [HALF_W-1:0]     a_wdata,
    output reg  [2*HALF_W-1:0]   a_rdata,
    input  wire [ADDR_W-1:0]     b_addr,
    output reg  [2*HALF_W-1:0]   b_rdata,
    input  wire                  c_we,
    input  wire [ADDR_W-1:0]     c_addr,
    input  wire [2*HALF_W-1:0]   c_wdata
);
    localparam DEPTH = 1 << ADDR_W;

    reg [2*HALF_W-1:0] mem [0:DEPTH-1];
    integer k;

    // Receive writes win a same-slot clash, since the CPU side has already been refused there.
    always @(posedge clock)
    begin
        if (srst)
        begin
            for (k = 0; k < DEPTH; k = k + 1)
                mem[k] <= {2*HALF_W{1'b0}};
            a_rdata <= {2*HALF_W{1'b0}};
            b_rdata <= {2*HALF_W{1'b0}};
        end
        else
        begin
            if (c_we)
                mem[c_addr] <= c_wdata;
            if (a_we[0] && !(c_we && (c_addr == a_addr)))
                mem[a_addr][HALF_W-1:0] <= a_wdata;
            if (a_we[1] && !(c_we && (c_addr == a_addr)))
                mem[a_addr][2*HALF_W-1:HALF_W] <= a_wdata;
            a_rdata <= mem[a_addr];
            b_rdata <= mem[b_addr];
        end
    end
endmodule

`default_nettype wire

// ===== bench/cmf_mailbox_filter_asserts.sv
// Port-level checker for the mailbox and filter block.
`timescale 1ns/1ps
`default_nettype none
module cmf_checker (
    input wire logic        clock, srst, psel, penable, pwrite, pslverr, rx_valid, rx_accept,
    input wire logic        tx_fetch, tx_pending, tx_frame_valid, tx_skip, write_denied_interrupt,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, prdata
);
    logic cdr_r;
    wire  fp = tx_fetch && tx_pending;
    wire  dw = psel && penable && pwrite && paddr[11:9] == 3'h1 && paddr[3];
    wire  cr = psel && penable && !pwrite && paddr[11:9] == 3'h1 && paddr[3:2] == 2'h1;
    // Copy of the update-request bit, which the block does not bring out.
    always @(posedge clock)
        cdr_r <= srst ? 1'b0 : (psel && penable && pwrite && paddr == 12'h010) ? pwdata[8] : cdr_r;
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    sequence s_fetch; fp; endsequence
    sequence s_answer; ##[1:2] (tx_frame_valid || tx_skip); endsequence
    a_slverr_access: assert property (pslverr |-> psel && penable) else $error("stray slverr");
    a_busy_fetch: assert property (s_fetch |=> !tx_pending || tx_skip) else $error("idle after fetch");
    a_fetch_answer: assert property (s_fetch |-> s_answer) else $error("no fetch answer");
    a_frame_cause: assert property (tx_frame_valid |-> $past(fp, 2)) else $error("frame");
    a_skip_cdr: assert property (tx_skip |-> $past(cdr_r) || $past(cdr_r, 2)) else $error("skip");
    a_wdi_muted: assert property (write_denied_interrupt |-> $past(dw && !cdr_r)) else $error("wdi");
    a_accept_cause: assert property (rx_accept |-> $past(rx_valid)) else $error("accept");
    a_ctrl_zero: assert property (cr |-> prdata[31:13] == 0 && prdata[7:5] == 0) else $error("rsvd");
endmodule
bind cmf_mailbox_filter cmf_checker u_chk (.*);
`default_nettype wire

// ===== bench/cmf_engine_model.sv
// Stand-in for the protocol engine: fetches pending frames and reports them sent.
`timescale 1ns/1ps
`default_nettype none
module cmf_engine_model (
    input  wire logic       clock, srst, stall, tx_pending, tx_frame_valid, tx_skip,
    input  wire logic [4:0] tx_mbox,
    output logic            tx_fetch, tx_done, tx_done_ok,
    output logic [4:0]      last_mbox,
    output logic [7:0]      sent_cnt
);
    logic busy_r;
    // One frame at a time; stall holds fetches back to play a slow bus.
    always @(posedge clock)
    begin
        tx_fetch <= !srst && !busy_r && !tx_fetch && tx_pending && !stall;
        tx_done <= !srst && tx_frame_valid;
        tx_done_ok <= !srst && tx_frame_valid;
        busy_r <= !srst && (busy_r || tx_fetch) && !tx_done && !tx_skip;
        sent_cnt <= srst ? 8'h00 : sent_cnt + 8'(tx_frame_valid);
        if (tx_frame_valid)
            last_mbox <= tx_mbox;
    end
endmodule
`default_nettype wire

// ===== bench/cmf_mailbox_filter_tb.sv
// Self-checking bench for the mailbox and filter block.
`timescale 1ns/1ps
`default_nettype none
module cmf_mailbox_filter_tb;
    logic clock = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, rx_valid = 0, rx_rtr = 0;
    logic rx_ide = 1, stall = 1, sv, wd, pready, pslverr, tx_pending, tx_fetch, tx_frame_valid;
    logic tx_skip, tx_done, tx_done_ok, rx_accept, write_denied_interrupt, tx_ide, tx_remote;
    logic [3:0] rx_dlc = 4'h8, tx_dlc;
    logic [4:0] tx_sel_mbox, tx_mbox, rx_mbox, last_mbox;
    logic [7:0] sent_cnt;
    logic [11:0] paddr = 12'h000;
    logic [28:0] rx_id = 29'h0, tx_id;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [63:0] rx_bytes = 64'h0807060504030201, tx_bytes;
    int err_count = 0, num_checks = 0, n;
    always #50 clock = ~clock;
    cmf_mailbox_filter DUT (.*);
    cmf_engine_model ENG (.*);
    function automatic logic [11:0] mb(input int m, w);
        return 12'(12'h200 + m * 16 + w * 4);
    endfunction
    task automatic chk(input logic [63:0] got, exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h", $time, got);
        end
    endtask
    // One transfer; data and error flag are taken at the pready edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock) penable <= 1;
        @(posedge clock);
        for (n = 0; n < 9 && pready !== 1'b1; n++)
            @(posedge clock);
        give_up(9);
        q = prdata;
        sv = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clock) wd = write_denied_interrupt;
    endtask
    task automatic t_regs();
        apb(0, 12'h010, 0);
        chk(q, 32'h00001000);
        apb(0, 12'h020, 0);
        chk({sv, q}, 33'h100000000);
        for (int m = 0; m < 7; m++)
            apb(1, mb(m, 1), 0);
        apb(1, mb(1, 0), 32'h00000123);
        apb(1, 12'h000, 32'h0000001E);
        apb(1, mb(1, 0), 32'h00000456);
        apb(0, mb(1, 0), 0);
        chk(q, 32'h00000123);
        apb(1, mb(1, 1), 32'hFFFFFFF8);
        apb(1, 12'h004, 32'h00000002);
        apb(1, mb(1, 1), 0);
        apb(1, mb(1, 2), 32'h000000AA);
        apb(0, mb(1, 1), 0);
        chk(q, 32'h00001F18);
        apb(0, mb(1, 2), 0);
        chk(q, 0);
        $display("register test done");
    endtask
    task automatic t_tx();
        int ord[3] = '{4, 3, 2};
        apb(1, mb(2, 1), 32'h00000508);
        apb(1, mb(3, 1), 32'h00000308);
        apb(1, mb(4, 1), 32'h00000508);
        apb(1, mb(2, 3), 32'h55667788);
        apb(1, 12'h010, 0);
        apb(1, 12'h008, 32'h0000001C);
        apb(1, mb(2, 2), 32'h11223344);
        chk(wd, 1);
        apb(0, mb(2, 2), 0);
        chk(q, 0);
        apb(1, 12'h010, 32'h00000102);
        apb(1, mb(3, 2), 32'h11223344);
        chk(wd, 0);
        apb(1, mb(2, 2), 32'hA1A2A3A4);
        apb(0, mb(2, 2), 0);
        chk(q, 32'hA1A2A3A4);
        stall <= 0;
        for (int k = 0; k < 3; k++)
        begin
            for (n = 0; n < 99 && sent_cnt != 8'(k + 1); n++)
                @(posedge clock);
            give_up(99);
            chk(last_mbox, ord[k]);
            if (k == 1)
                apb(1, 12'h010, 0);
            if (k == 2)
                chk(tx_bytes, 64'h88776655A4A3A2A1);
            if (k == 2)
                chk({tx_ide, tx_remote, tx_dlc, tx_id}, 35'h100000000);
        end
        $display("transmit test done");
    endtask
    task automatic t_rx();
        logic [28:0] ids[4] = '{29'h0ABCDE5, 29'h0ABCDE7, 29'h0ABCDF0, 29'h0ABCDE6};
        logic [5:0] res[4] = '{6'h26, 6'h25, 6'h05, 6'h05};
        apb(1, mb(5, 0), 32'hC0ABCDE0);
        apb(1, mb(6, 0), 32'h80ABCDE5);
        apb(1, 12'h114, 32'h0000000F);
        apb(1, 12'h004, 32'h00000062);
        apb(1, 12'h000, 32'h0000007E);
        for (int k = 0; k < 4; k++)
        begin
            if (k == 3)
                apb(1, 12'h010, 32'h00002000);
            rx_id <= ids[k];
            rx_valid <= 1;
            @(posedge clock) rx_valid <= 0;
            @(posedge clock);
            chk({rx_accept, rx_mbox}, res[k]);
        end
        apb(0, mb(5, 2), 0);
        chk(q, 32'h01020304);
        $display("receive test done");
    endtask
    task automatic give_up(input int lim);
        if (n >= lim)
        begin
            err_count++;
            $display("wrong value at %0t: wait ran out", $time);
            finish_test();
        end
    endtask
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge clock);
        srst <= 0;
        @(posedge clock);
        t_regs();
        t_tx();
        t_rx();
        finish_test();
    end
endmodule
`default_nettype wire
